// file: core/clm_pkg.sv
package clm_pkg;

  // one set of strap fields as seen on the selection pins
  typedef struct packed {
    logic [2:0] fec;
    logic [2:0] outRng;
    logic [2:0] inRng;
  } clm_sel_t;

  // multiplication factor as numerator over denominator
  typedef struct packed {
    logic [15:0] num;
    logic [15:0] den;
  } clm_ratio_t;

  // fec scaling factor on its own
  typedef struct packed {
    logic [7:0] num;
    logic [7:0] den;
  } clm_fec_t;

  typedef enum logic [2:0] {
    IN_RSV_LO = 3'h0,
    IN_19     = 3'h1,
    IN_38     = 3'h2,
    IN_77     = 3'h3,
    IN_155    = 3'h4,
    IN_311    = 3'h5,
    IN_622    = 3'h6,
    IN_RSV_HI = 3'h7
  } clm_in_rng_t;

  typedef enum logic [2:0] {
    OUT_39   = 3'h0,
    OUT_19   = 3'h1,
    OUT_155  = 3'h2,
    OUT_622  = 3'h3,
    OUT_78   = 3'h4,
    OUT_311  = 3'h5,
    OUT_1G25 = 3'h6,
    OUT_2G5  = 3'h7
  } clm_out_rng_t;

  typedef enum logic [2:0] {
    FEC_NONE  = 3'h0,
    FEC_UP238 = 3'h1,
    FEC_DN238 = 3'h2,
    FEC_RSV   = 3'h3,
    FEC_UP237 = 3'h4,
    FEC_DN237 = 3'h5,
    FEC_UP64  = 3'h6,
    FEC_DN64  = 3'h7
  } clm_fec_code_t;

endpackage

// file: core/clm_rate_select.sv
`timescale 1ns/1ns
`include "clm_regs.svh"
module clm_rate_select #(
  parameter int unsigned AW = 12
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [AW-1:0]      paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire clm_pkg::clm_sel_t  pinSel,
  input  wire logic [2:0]         pinDriven,
  output clm_pkg::clm_ratio_t     ratio,
  output logic [19:0]             inFreqKhz,
  output logic                    cfgError,
  output logic                    recalNeeded
);
  import clm_pkg::*;

  // synchronised pin levels and pad-driven sense
  logic [2:0]  inSync;
  logic [2:0]  outSync;
  logic [2:0]  fecSync;
  logic [2:0]  drvSync;

  // software control state
  logic        ovr_q;        // software selection replaces the pins
  clm_sel_t    swSel_q;      // software copy of the three fields
  clm_sel_t    prevSel_q;    // last applied selection, for change sense
  logic        primed_q;     // prevSel_q holds a real value
  logic        recal_q;      // sticky: fec code changed since cleared
  logic        cfgErr_q;
  logic        inRsv_q;
  logic        fecRsv_q;
  logic        fecRng_q;
  clm_ratio_t  ratio_q;
  logic [19:0] freq_q;
  logic [31:0] prdata_q;

  // the four pin groups share one synchroniser design
  clm_sync #(.W(3)) u_syncIn  (.clk(clk), .rst(rst), .ce(ce),
                               .d(pinSel.inRng),  .q(inSync));
  clm_sync #(.W(3)) u_syncOut (.clk(clk), .rst(rst), .ce(ce),
                               .d(pinSel.outRng), .q(outSync));
  clm_sync #(.W(3)) u_syncFec (.clk(clk), .rst(rst), .ce(ce),
                               .d(pinSel.fec),    .q(fecSync));
  clm_sync #(.W(3)) u_syncDrv (.clk(clk), .rst(rst), .ce(ce),
                               .d(pinDriven),     .q(drvSync));

  // an undriven field is seen as all zeros, like a pulled-down pad
  clm_sel_t pinEff;
  assign pinEff.inRng  = drvSync[0] ? inSync  : 3'h0;
  assign pinEff.outRng = drvSync[1] ? outSync : 3'h0;
  assign pinEff.fec    = drvSync[2] ? fecSync : 3'h0;

  // the selection actually applied
  clm_sel_t sel;
  assign sel = ovr_q ? swSel_q : pinEff;

  // input code to power-of-two step above 19.44 MHz
  function automatic logic [2:0] inStep(input logic [2:0] c);
    case (c)
      IN_19:   inStep = 3'h0;
      IN_38:   inStep = 3'h1;
      IN_77:   inStep = 3'h2;
      IN_155:  inStep = 3'h3;
      IN_311:  inStep = 3'h4;
      IN_622:  inStep = 3'h5;
      default: inStep = 3'h0;  // reserved, flagged separately
    endcase
  endfunction

  // output code to power-of-two step above the 19 MHz range
  function automatic logic [2:0] outStep(input logic [2:0] c);
    case (c)
      OUT_19:   outStep = 3'h0;
      OUT_39:   outStep = 3'h1;
      OUT_78:   outStep = 3'h2;
      OUT_155:  outStep = 3'h3;
      OUT_311:  outStep = 3'h4;
      OUT_622:  outStep = 3'h5;
      OUT_1G25: outStep = 3'h6;
      default:  outStep = 3'h7;
    endcase
  endfunction

  // fec code to its scaling ratio; the reserved code scales by one
  function automatic clm_fec_t fecRatio(input logic [2:0] c);
    case (c)
      FEC_UP238: fecRatio = '{`CLM_FEC_255, `CLM_FEC_238};
      FEC_DN238: fecRatio = '{`CLM_FEC_238, `CLM_FEC_255};
      FEC_UP237: fecRatio = '{`CLM_FEC_255, `CLM_FEC_237};
      FEC_DN237: fecRatio = '{`CLM_FEC_237, `CLM_FEC_255};
      FEC_UP64:  fecRatio = '{`CLM_FEC_66,  `CLM_FEC_64};
      FEC_DN64:  fecRatio = '{`CLM_FEC_64,  `CLM_FEC_66};
      default:   fecRatio = '{`CLM_FEC_ONE, `CLM_FEC_ONE};
    endcase
  endfunction

  // range decode and error terms
  wire [2:0]  kIn    = inStep(sel.inRng);
  wire [2:0]  jOut   = outStep(sel.outRng);
  wire        inRsv  = (sel.inRng == IN_RSV_LO) ||
                       (sel.inRng == IN_RSV_HI);
  wire        fecRsv = (sel.fec == FEC_RSV);
  wire        fecBig = sel.fec[2];                         // 100..111
  wire        inFast = (sel.inRng >= IN_155) && !inRsv;
  wire        fecRng = fecBig && !inFast;
  wire        cfgErr = inRsv || fecRsv || fecRng;
  clm_fec_t   fecR;
  assign fecR = fecRatio(sel.fec);

  // power-of-two part of the factor; a slower output moves to den
  wire [2:0]  upSh = (jOut > kIn) ? 3'(jOut - kIn) : 3'h0;
  wire [2:0]  dnSh = (kIn > jOut) ? 3'(kIn - jOut) : 3'h0;
  clm_ratio_t ratioD;
  assign ratioD.num = {8'h00, fecR.num} << upSh;
  assign ratioD.den = {8'h00, fecR.den} << dnSh;

  // nominal input is 19.44 MHz doubled per step, exact in khz
  wire [19:0] freqD = `CLM_IN_KHZ_BASE << kIn;

  // fec change seen once the first selection is in hand
  wire        fecChg = primed_q && (prevSel_q.fec != sel.fec);

  // apb decode
  wire        acc     = psel && penable;
  wire        isCtrl  = (paddr == `CLM_CTRL_OFS);
  wire        isStat  = (paddr == `CLM_STAT_OFS);
  wire        isNum   = (paddr == `CLM_NUM_OFS);
  wire        isDen   = (paddr == `CLM_DEN_OFS);
  wire        isFreq  = (paddr == `CLM_FREQ_OFS);
  wire        mapped  = isCtrl || isStat || isNum || isDen || isFreq;
  wire        wrCtrl  = acc && pwrite && isCtrl;
  wire        wrStat  = acc && pwrite && isStat;
  wire        clrRec  = wrStat && pwdata[`CLM_STAT_RECAL];
  wire        setupRd = psel && !penable && !pwrite;

  // readable words
  logic [31:0] ctrlWord;
  logic [31:0] statWord;
  always_comb
  begin
    ctrlWord = 32'h0000_0000;
    ctrlWord[`CLM_CTRL_OVR_BIT]       = ovr_q;
    ctrlWord[`CLM_CTRL_IN_LSB +: 3]   = swSel_q.inRng;
    ctrlWord[`CLM_CTRL_OUT_LSB +: 3]  = swSel_q.outRng;
    ctrlWord[`CLM_CTRL_FEC_LSB +: 3]  = swSel_q.fec;
    statWord = 32'h0000_0000;
    statWord[`CLM_STAT_INRSV]         = inRsv_q;
    statWord[`CLM_STAT_FECRSV]        = fecRsv_q;
    statWord[`CLM_STAT_FECRNG]        = fecRng_q;
    statWord[`CLM_STAT_CFGERR]        = cfgErr_q;
    statWord[`CLM_STAT_RECAL]         = recal_q;
    statWord[`CLM_STAT_IN_LSB +: 3]   = prevSel_q.inRng;
    statWord[`CLM_STAT_OUT_LSB +: 3]  = prevSel_q.outRng;
    statWord[`CLM_STAT_FEC_LSB +: 3]  = prevSel_q.fec;
  end

  wire [31:0] rdMux = isCtrl ? ctrlWord :
                      isStat ? statWord :
                      isNum  ? {16'h0000, ratio_q.num} :
                      isDen  ? {16'h0000, ratio_q.den} :
                      isFreq ? {12'h000, freq_q} : 32'h0000_0000;

  // software control register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ovr_q   <= `CLM_OVR_RST;
      swSel_q <= `CLM_SWSEL_RST;
    end
    else if (ce && wrCtrl)
    begin
      ovr_q          <= pwdata[`CLM_CTRL_OVR_BIT];
      swSel_q.inRng  <= pwdata[`CLM_CTRL_IN_LSB +: 3];
      swSel_q.outRng <= pwdata[`CLM_CTRL_OUT_LSB +: 3];
      swSel_q.fec    <= pwdata[`CLM_CTRL_FEC_LSB +: 3];
    end
  end

  // decoded factor and error flags, one register stage after select
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ratio_q  <= `CLM_RATIO_RST;
      freq_q   <= `CLM_FREQ_RST;
      cfgErr_q <= 1'b0;
      inRsv_q  <= 1'b0;
      fecRsv_q <= 1'b0;
      fecRng_q <= 1'b0;
    end
    else if (ce)
    begin
      ratio_q  <= ratioD;
      freq_q   <= freqD;
      cfgErr_q <= cfgErr;
      inRsv_q  <= inRsv;
      fecRsv_q <= fecRsv;
      fecRng_q <= fecRng;
    end
  end

  // recalibration request: a fec change sets it, a write of one
  // clears it; a change in the clearing cycle wins so none is lost
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prevSel_q <= `CLM_SWSEL_RST;
      primed_q  <= 1'b0;
      recal_q   <= 1'b0;
    end
    else if (ce)
    begin
      prevSel_q <= sel;
      primed_q  <= 1'b1;
      if (fecChg)
        recal_q <= 1'b1;
      else if (clrRec)
        recal_q <= 1'b0;
    end
  end

  // read data is captured in the setup cycle, so no wait states
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prdata_q <= 32'h0000_0000;
    else if (ce && setupRd)
      prdata_q <= rdMux;
  end

  assign prdata      = prdata_q;
  assign pready      = 1'b1;
  assign pslverr     = acc && !mapped;
  assign ratio       = ratio_q;
  assign inFreqKhz   = freq_q;
  assign cfgError    = cfgErr_q;
  assign recalNeeded = recal_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_undriven;
    (ce && !ovr_q && pinDriven == 3'h0)[*4];
  endsequence

  sequence s_same_range;
    ce && !inRsv && kIn == jOut;
  endsequence

  a_in_reserved: assert property (
    (ce && inRsv) |=> cfgErr_q && inRsv_q)
    else $error("reserved input code not flagged");

  a_freq_nominal: assert property (
    (ce && sel.inRng == IN_155) |=> freq_q == 20'h25f80)
    else $error("155 MHz range nominal frequency wrong");

  a_out_low: assert property (
    (ce && sel.inRng == IN_19 && sel.outRng == OUT_155
     && sel.fec == FEC_NONE) |=> ratio_q == 32'h0008_0001)
    else $error("155 MHz output from 19 MHz input not eight");

  a_out_high: assert property (
    (ce && sel.inRng == IN_19 && sel.outRng == OUT_2G5
     && sel.fec == FEC_NONE) |=> ratio_q == 32'h0080_0001)
    else $error("2.5 GHz output from 19 MHz input not 128");

  a_down_ratio: assert property (
    (ce && sel.inRng == IN_622 && sel.outRng == OUT_19
     && sel.fec == FEC_NONE) |=> ratio_q == 32'h0001_0020)
    else $error("19 MHz output from 622 MHz input not 1/32");

  a_no_scaling: assert property (
    (s_same_range and sel.fec == FEC_NONE) |=> ratio_q == 32'h0001_0001)
    else $error("fec 000 changed the factor");

  a_fec_238: assert property (
    (s_same_range and sel.fec == FEC_UP238) |=>
      ratio_q == {8'h00, `CLM_FEC_255, 8'h00, `CLM_FEC_238})
    else $error("fec 001 not 255/238");

  a_fec_237: assert property (
    (s_same_range and sel.fec == FEC_DN237) |=>
      ratio_q == {8'h00, `CLM_FEC_237, 8'h00, `CLM_FEC_255})
    else $error("fec 101 not 237/255");

  a_fec_64: assert property (
    (s_same_range and sel.fec == FEC_UP64) |=>
      ratio_q == {8'h00, `CLM_FEC_66, 8'h00, `CLM_FEC_64})
    else $error("fec 110 not 66/64");

  a_fec_slow_in: assert property (
    (ce && fecBig && sel.inRng < IN_155) |=> cfgErr_q && fecRng_q)
    else $error("large fec ratio on slow input not flagged");

  a_fec_reserved: assert property (
    (ce && sel.fec == FEC_RSV) |=> cfgErr_q && fecRsv_q)
    else $error("reserved fec code not flagged");

  a_cfg_clean: assert property (
    (ce && !cfgErr) |=> !cfgErr_q)
    else $error("error flag raised on a clean selection");

  a_recal_set: assert property (
    (ce && fecChg) |=> recalNeeded ##1 (recalNeeded || (ce && clrRec)))
    else $error("fec change did not request recalibration");

  a_undriven_zero: assert property (
    s_undriven |=> cfgErr_q && sel.inRng == IN_RSV_LO)
    else $error("undriven pins not read as zero");

endmodule // clm_rate_select

// file: core/clm_regs.svh
`ifndef CLM_REGS_SVH
`define CLM_REGS_SVH

// register byte offsets on the apb slave
`define CLM_CTRL_OFS     12'h000
`define CLM_STAT_OFS     12'h004
`define CLM_NUM_OFS      12'h008
`define CLM_DEN_OFS      12'h00c
`define CLM_FREQ_OFS     12'h010

// control word field positions
`define CLM_CTRL_OVR_BIT 0
`define CLM_CTRL_IN_LSB  4
`define CLM_CTRL_OUT_LSB 8
`define CLM_CTRL_FEC_LSB 12

// status word field positions
`define CLM_STAT_INRSV   0
`define CLM_STAT_FECRSV  1
`define CLM_STAT_FECRNG  2
`define CLM_STAT_CFGERR  3
`define CLM_STAT_RECAL   4
`define CLM_STAT_IN_LSB  8
`define CLM_STAT_OUT_LSB 12
`define CLM_STAT_FEC_LSB 16

// reset values
`define CLM_OVR_RST      1'b0
`define CLM_SWSEL_RST    9'h000
`define CLM_RATIO_RST    32'h0001_0001
`define CLM_FREQ_RST     20'h00000

// scaling factors and nominal base input frequency in khz
`define CLM_FEC_ONE      8'h01
`define CLM_FEC_255      8'hff
`define CLM_FEC_238      8'hee
`define CLM_FEC_237      8'hed
`define CLM_FEC_66       8'h42
`define CLM_FEC_64       8'h40
`define CLM_IN_KHZ_BASE  20'h04bf0

`endif

// file: core/clm_sync.sv
`timescale 1ns/1ns
// two-flop synchroniser for a group of static pins
module clm_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import clm_pkg::*;

  logic [W-1:0] meta_q;  // first stage, read only by the second

  // both stages reset to zero so an idle pin reads low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else if (ce)
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // clm_sync

// file: tb/clm_strap_model.sv
`timescale 1ns/1ns
// board logic strapping the selection pins of the rate selector
module clm_strap_model (
  input  wire logic              clk,
  input  wire clm_pkg::clm_sel_t wantSel,
  input  wire logic [2:0]        wantDriven,
  input  wire logic              allowMisuse,
  output clm_pkg::clm_sel_t      pinSel,
  output logic [2:0]             pinDriven
);
  import clm_pkg::*;

  logic     slowIn;  // input range below the 155 MHz range, or a reserved code
  logic     wob = 1'b0; // level an undriven field shows, flips each edge
  logic     [2:0] fecPick; // fec code actually strapped
  assign slowIn = !(wantSel.inRng inside {3'h4, 3'h5, 3'h6});
  // large fec ratios only with a fast input, unless a misuse is wanted
  assign fecPick = (wantSel.fec[2] && slowIn && !allowMisuse) ?
                   3'h0 : wantSel.fec;

  // an undriven field wanders so a stale level cannot pass for zero
  always @(posedge clk)
  begin
    wob           <= ~wob;
    pinDriven     <= wantDriven;
    pinSel.inRng  <= wantDriven[0] ? wantSel.inRng : {3{wob}};
    pinSel.outRng <= wantDriven[1] ? wantSel.outRng : {3{wob}};
    pinSel.fec    <= wantDriven[2] ? fecPick : {3{wob}};
  end
endmodule // clm_strap_model

// file: tb/testbench.sv
`timescale 1ns/1ns
`include "clm_regs.svh"
// compare, count, and report a mismatch at once
`define CHK(nm, ex, got) begin samples_checked++; \
  if ((got) !== (ex)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module testbench;
  import clm_pkg::*;

  logic       clk, rst, ce, psel, penable, pwrite, pready, pslverr;
  logic       [11:0] paddr;
  logic       [31:0] pwdata, prdata, rdata;
  logic       rerr;                 // response code of the last transfer
  clm_sel_t   pinSel, wantSel;      // pins and wanted strap
  logic       [2:0] pinDriven, wantDriven;
  logic       allowMisuse;
  clm_ratio_t ratio;
  logic       [19:0] inFreqKhz;
  logic       cfgError, recalNeeded;
  int         n_mismatch, samples_checked;

  clm_rate_select i_dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinSel(pinSel),
    .pinDriven(pinDriven), .ratio(ratio), .inFreqKhz(inFreqKhz),
    .cfgError(cfgError), .recalNeeded(recalNeeded));

  clm_strap_model i_strap (.clk(clk), .wantSel(wantSel),
    .wantDriven(wantDriven), .allowMisuse(allowMisuse), .pinSel(pinSel),
    .pinDriven(pinDriven));

  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // one apb transfer; an idle edge first keeps drivers single per step
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected factor: fec ratio shifted by the range step difference
  function automatic clm_ratio_t expR(logic [2:0] i, o, f);
    int j, k;
    logic [7:0] fn, fd;
    k = (i == 3'h0 || i == 3'h7) ? 0 : int'(i) - 1;
    case (o)
      3'h0: j = 1; 3'h1: j = 0; 3'h2: j = 3; 3'h3: j = 5;
      3'h4: j = 2; 3'h5: j = 4; 3'h6: j = 6; default: j = 7;
    endcase
    case (f)
      3'h1: {fn, fd} = {8'hff, 8'hee}; 3'h2: {fn, fd} = {8'hee, 8'hff};
      3'h4: {fn, fd} = {8'hff, 8'hed}; 3'h5: {fn, fd} = {8'hed, 8'hff};
      3'h6: {fn, fd} = {8'h42, 8'h40}; 3'h7: {fn, fd} = {8'h40, 8'h42};
      default: {fn, fd} = {8'h01, 8'h01};
    endcase
    expR.num = 16'(fn) << ((j > k) ? j - k : 0);
    expR.den = 16'(fd) << ((k > j) ? k - j : 0);
  endfunction

  function automatic logic expE(logic [2:0] i, f);
    return i == 3'h0 || i == 3'h7 || f == 3'h3 ||
           (f[2] && !(i inside {3'h4, 3'h5, 3'h6}));
  endfunction

  // select through the override fields, then give the decode two edges
  task automatic ovr(input logic [2:0] i, o, f);
    apb(1'b1, `CLM_CTRL_OFS, {17'h0, f, 1'b0, o, 1'b0, i, 4'h1});
    repeat (2) @(posedge clk);
  endtask

  task automatic t_regs;
    apb(1'b0, `CLM_CTRL_OFS, 32'h0);
    `CHK("ctrl reset", 32'h0, rdata)
    `CHK("mapped err", 1'b0, rerr)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped err", 1'b1, rerr)
  endtask

  // every input code against every output code, no fec scaling
  task automatic t_ranges;
    for (int i = 0; i < 8; i++)
      for (int o = 0; o < 8; o++)
      begin
        ovr(3'(i), 3'(o), 3'h0);
        `CHK("ratio", expR(3'(i), 3'(o), 3'h0), ratio)
        `CHK("cfg err", expE(3'(i), 3'h0), cfgError)
        if (i > 0 && i < 7)
          `CHK("in freq", 20'h04bf0 << (i - 1), inFreqKhz)
      end
  endtask

  // every fec code on a fast input, then the large ones on a slow input
  task automatic t_fec;
    for (int f = 0; f < 8; f++)
    begin
      ovr(3'h4, 3'h2, 3'(f));
      `CHK("fec ratio", expR(3'h4, 3'h2, 3'(f)), ratio)
      `CHK("fec err", expE(3'h4, 3'(f)), cfgError)
      `CHK("recal", f > 0, recalNeeded)
      apb(1'b1, `CLM_STAT_OFS, 32'h10);
    end
    for (int f = 4; f < 8; f++)
    begin
      ovr(3'h3, 3'h7, 3'(f));
      `CHK("slow fec err", 1'b1, cfgError)
    end
    apb(1'b1, `CLM_STAT_OFS, 32'h10);
    repeat (2) @(posedge clk);
    `CHK("recal clear", 1'b0, recalNeeded)
    ovr(3'h3, 3'h7, 3'h7);
    `CHK("recal same fec", 1'b0, recalNeeded)
  endtask

  // strap pins instead of the override, with a floating input range field
  task automatic t_pins;
    apb(1'b1, `CLM_CTRL_OFS, 32'h0);
    wantSel <= '{fec: 3'h6, outRng: 3'h6, inRng: 3'h5};
    wantDriven <= 3'h7;
    repeat (6) @(posedge clk);
    `CHK("pin ratio", expR(3'h5, 3'h6, 3'h6), ratio)
    `CHK("pin freq", 20'h04bf0 << 4, inFreqKhz)
    apb(1'b0, `CLM_STAT_OFS, 32'h0);
    `CHK("stat out", 3'h6, rdata[14:12])
    wantDriven <= 3'h6;
    repeat (6) @(posedge clk);
    `CHK("float ratio", expR(3'h0, 3'h6, 3'h6), ratio)
    `CHK("float err", 1'b1, cfgError)
    wantSel <= '{fec: 3'h4, outRng: 3'h6, inRng: 3'h2};
    wantDriven <= 3'h7;
    repeat (6) @(posedge clk);
    `CHK("kept ratio", expR(3'h2, 3'h6, 3'h0), ratio)
    allowMisuse <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("misuse err", 1'b1, cfgError)
  endtask

  // clock enable low freezes the decode; then a reset in mid-run
  task automatic t_hold;
    ce <= 1'b0;
    wantSel <= '{fec: 3'h0, outRng: 3'h3, inRng: 3'h6};
    repeat (6) @(posedge clk);
    `CHK("ce hold", expR(3'h2, 3'h6, 3'h4), ratio)
    `CHK("ce hold err", 1'b1, cfgError)
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("ce run", expR(3'h6, 3'h3, 3'h0), ratio)
    `CHK("ce run err", 1'b0, cfgError)
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("rst ratio", 32'h0001_0001, ratio)
    `CHK("rst freq", 20'h00000, inFreqKhz)
    `CHK("rst err", 1'b0, cfgError)
    `CHK("rst recal", 1'b0, recalNeeded)
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("rerun ratio", expR(3'h6, 3'h3, 3'h0), ratio)
    `CHK("rerun err", 1'b0, cfgError)
    `CHK("rerun recal", 1'b0, recalNeeded)
  endtask

  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // the whole run needs about 500 cycles
  initial
  begin
    #40000;
    n_mismatch++;
    end_sim();
  end

  initial
  begin
    {rst, ce, psel, penable, pwrite, allowMisuse} = 6'b110000;
    paddr = '0; pwdata = '0; wantSel = '0; wantDriven = 3'h0;
    n_mismatch = 0; samples_checked = 0;
    repeat (4) @(posedge clk);
    `CHK("reset ratio", 32'h0001_0001, ratio)
    `CHK("reset recal", 1'b0, recalNeeded)
    rst <= 1'b0;
    t_regs();
    t_ranges();
    t_fec();
    t_pins();
    t_hold();
    end_sim();
  end
endmodule // testbench
